// ===== inc/bse_pkg.sv
// Purpose: Shared constants, command layout and enumerations of the barrel shifter exponent unit.
// Assumes: Registers are 32-bit Wishbone words at byte offsets that are multiples of four.
// Notes:   Exponents are 8-bit twos-complement values throughout.
//
// Behaviour
// RULE_01: Extended-high mode with ALU overflow set gives exponent +1.
// RULE_02: Extended-high mode without overflow detects exactly like upper-half mode.
// RULE_03: Exponent derivation in upper or extended mode loads the shifter sign flag.
// RULE_04: Sign flag is input MSB, inverted only in extended mode with overflow.
// RULE_05: Upper-half exponent is 0 for one sign bit, down to -15.
// RULE_06: Lower-half mode takes the stored sign flag as the number's sign.
// RULE_07: Lower-half mode writes the shift exponent only when it holds -15.
// RULE_08: Lower-half exponent is offset by -16, ranging -15 down to -31.
// RULE_09: Software processes the upper half before the lower half.
// RULE_10: Block exponent is overwritten only by a strictly greater derived exponent.
// RULE_11: Five operations: arithmetic, logical, normalize, derive exponent, block adjust.
// RULE_12: The three shift operations accept OR-merge and upper or lower reference.
// RULE_13: OR-merge ORs the shift output into the current shift result.
// RULE_14: Without OR-merge the shift output replaces the shift result.
// RULE_15: Upper reference aligns to result bits 31:16, lower to 15:0.
// RULE_16: Operand comes from shift input or a result register; result is 32-bit.
// RULE_17: Derive exponent writes the detected exponent into the shift exponent.
// RULE_18: Normalize shifts by the negated shift exponent.
// RULE_19: Block adjust only inspects and updates block exponent, data unchanged.
// RULE_20: Immediate shifts use an 8-bit signed amount and leave the exponent alone.

package bse_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFF_CMD   = 8'h00;
   localparam logic [7:0] OFF_SI    = 8'h04;
   localparam logic [7:0] OFF_SE    = 8'h08;
   localparam logic [7:0] OFF_SB    = 8'h0c;
   localparam logic [7:0] OFF_SR    = 8'h10;
   localparam logic [7:0] OFF_ARITH_STATUS_REG = 8'h14;

   // Status register bit positions.
   localparam int ARITH_STATUS_REG_SS_BIT = 0;
   localparam int ARITH_STATUS_REG_AV_BIT = 1;

   // Exponent constants and reset values.
   localparam logic [7:0]  EXP_OVF      = 8'h01;
   localparam logic [7:0]  EXP_ZERO     = 8'h00;
   localparam logic [7:0]  EXP_HI_FLOOR = 8'hf1;
   localparam logic [7:0]  EXP_LO_BASE  = 8'hf1;
   localparam logic [7:0]  SE_RESET     = 8'h00;
   localparam logic [7:0]  SB_RESET     = 8'hf0;
   localparam logic [31:0] SR_RESET     = 32'h0000_0000;
   localparam logic [15:0] SI_RESET     = 16'h0000;
   localparam logic [31:0] CMD_RESET    = 32'h0000_0000;
   localparam logic [7:0]  SHIFT_CLAMP  = 8'h20;

   // Operations; codes 6 and 7 do nothing.
   typedef enum logic [2:0] {
      OP_NONE,
      OP_ARITH_SHIFT_OP,
      OP_LOGICAL_SHIFT_OP,
      OP_MANTISSA_ALIGN_OP,
      OP_EXP,
      OP_BLOCK_SCALE_ADJUST_OP
   } bse_op_t;

   // Half reference and detector mode; code 3 acts as upper-half.
   typedef enum logic [1:0] {
      MODE_HI,
      MODE_LO,
      MODE_HIX
   } bse_mode_t;

   // Operand sources.
   typedef enum logic [1:0] {
      SRC_SI,
      SRC_ALU,
      SRC_SR_LO,
      SRC_SR_HI
   } bse_src_t;

   // Command word layout as written to OFF_CMD.
   typedef struct packed {
      logic [7:0] rsvd_top;
      logic [7:0] imm_amt;
      logic [5:0] rsvd_mid;
      logic [1:0] src;
      logic       rsvd_low;
      logic       use_imm;
      logic       or_into;
      logic [1:0] mode;
      logic [2:0] op;
   } bse_cmd_t;

endpackage

// ===== logic/bse_exp_detect.sv
// Purpose: Exponent detector for upper, extended-upper and lower half modes.
// Assumes: Purely combinational; stored sign flag is supplied by the caller.
// Notes:   Output is an 8-bit twos-complement exponent.

`timescale 1ns/1ps

module bse_exp_detect
   import bse_pkg::*;
(
   input  wire logic [15:0] operand_i,
   input  wire logic [1:0]  mode_i,
   input  wire logic        av_i,
   input  wire logic        ss_i,
   output logic      [7:0]  exp_o,
   output logic             sign_o
);

   logic [4:0] run;
   logic       stop;
   logic       sign;
   logic       lo;
   logic [4:0] top;

   // Count redundant sign bits from the top of the field downward.
   always_comb begin
      lo   = (mode_i == MODE_LO);
      sign = lo ? ss_i : operand_i[15];           // RULE_06 RULE_04
      top  = lo ? 5'd15 : 5'd14;                  // Upper modes skip the sign bit itself.
      run  = 5'd0;
      stop = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if ((5'(i) <= top) && !stop) begin
            if (operand_i[i] == sign) begin
               run = run + 5'd1;
            end else begin
               stop = 1'b1;
            end
         end
      end
      if (lo) begin
         exp_o = EXP_LO_BASE - {3'b000, run};     // RULE_08
      end else begin
         exp_o = EXP_ZERO - {3'b000, run};        // RULE_05 RULE_02
      end
      sign_o = sign;
      // An overflowed ALU sum needs the carry as an extra mantissa bit.
      if ((mode_i == MODE_HIX) && av_i) begin
         exp_o  = EXP_OVF;                        // RULE_01
         sign_o = ~operand_i[15];                 // RULE_04
      end
   end

endmodule

// ===== logic/bse_top.sv
// Purpose: Barrel shifter exponent unit with Wishbone register access.
// Assumes: alu_result_i and alu_overflow_i come from logic on clk_i.
// Notes:   A command write executes in the same edge that commits it.
//          Each group of state has its own next-value and register process.

`timescale 1ns/1ps

module bse_top
   import bse_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [15:0] alu_result_i,
   input  wire logic        alu_overflow_i,
   output logic      [31:0] shift_result_o,
   output logic      [7:0]  shift_exponent_o,
   output logic      [7:0]  block_exponent_o,
   output logic             shifter_sign_o
);

   // Merge write data into an old word under the byte enables.
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Match a byte address against a register offset, ignoring the lane bits.
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      return {adr[7:2], 2'b00} == off;
   endfunction

   // True for the three operations that move data into the shift result.
   function automatic logic moves_data(input bse_op_t o);
      return (o == OP_ARITH_SHIFT_OP) || (o == OP_LOGICAL_SHIFT_OP) || (o == OP_MANTISSA_ALIGN_OP);
   endfunction

   // True when a mode field references the lower half of the result.
   function automatic logic lower_half(input logic [1:0] md);
      return md == MODE_LO;
   endfunction

   // Registered state; each next value sits beside its register.
   logic [31:0] cmd_q,   cmd_d;
   logic [15:0] si_q,    si_d;
   logic [7:0]  se_q,    se_d;
   logic [7:0]  sb_q,    sb_d;
   logic [31:0] sr_q,    sr_d;
   logic        ss_q,    ss_d;
   logic        ack_q,   ack_d;
   logic [31:0] dat_q,   dat_d;

   // Bus decode and shifter datapath nets.
   logic        req;
   logic        wr;
   logic        cmd_go;
   logic        wr_si;
   logic        wr_se;
   logic        wr_sb;
   logic        wr_sr;
   logic        wr_ss;
   bse_cmd_t    cmd;
   bse_op_t     op;
   logic [15:0] operand;
   logic [7:0]  det_exp;
   logic        det_sign;
   logic [7:0]  amt;
   logic [7:0]  mag;
   logic        fill;
   logic [31:0] placed;
   logic [63:0] wide;
   logic [31:0] shifted;
   logic [31:0] rd_mux;
   logic [31:0] arith_status_reg_word;

   // A new request is one strobe that has not yet been acknowledged.
   assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr     = req & wb_we_i;
   assign cmd_go = wr & hit(wb_adr_i, OFF_CMD);

   // Per-register write strobes. The status word's one writable bit, the sign flag, sits in
   // its low byte, so its strobe also needs that byte lane.
   assign wr_si  = wr & hit(wb_adr_i, OFF_SI);
   assign wr_se  = wr & hit(wb_adr_i, OFF_SE);
   assign wr_sb  = wr & hit(wb_adr_i, OFF_SB);
   assign wr_sr  = wr & hit(wb_adr_i, OFF_SR);
   assign wr_ss  = wr & hit(wb_adr_i, OFF_ARITH_STATUS_REG) & wb_sel_i[0];

   // Decode the command being written now; it executes at the commit edge.
   always_comb begin
      cmd = bse_cmd_t'(lane_merge(cmd_q, wb_dat_i, wb_sel_i));
      op  = bse_op_t'(cmd.op);
   end

   // Operand source select. Either half of the shift result can feed back,
   // which is how a double word is walked through the shifter.
   always_comb begin
      unique case (bse_src_t'(cmd.src))
         SRC_SI:    operand = si_q;               // RULE_16
         SRC_ALU:   operand = alu_result_i;       // RULE_16
         SRC_SR_LO: operand = sr_q[15:0];
         SRC_SR_HI: operand = sr_q[31:16];
      endcase
   end

   bse_exp_detect u_detect (
      .operand_i (operand),
      .mode_i    (cmd.mode),
      .av_i      (alu_overflow_i),
      .ss_i      (ss_q),
      .exp_o     (det_exp),
      .sign_o    (det_sign)
   );

   // Shift amount, placement and fill. Positive amounts shift left.
   always_comb begin
      if (cmd.use_imm) begin
         amt = cmd.imm_amt;                       // RULE_20
      end else if (op == OP_MANTISSA_ALIGN_OP) begin
         amt = 8'h00 - se_q;                      // RULE_18
      end else begin
         amt = se_q;
      end
      mag = amt[7] ? (8'h00 - amt) : amt;
      // A right shift pulls fill bits down from a 64-bit word, so clamping at 32
      // leaves a pure fill pattern instead of zero bits for any amount above 32.
      if (mag > SHIFT_CLAMP) begin
         mag = SHIFT_CLAMP;
      end
      // Normalize with upper reference restores the stored sign on a right shift after overflow.
      if (op == OP_ARITH_SHIFT_OP) begin
         fill = operand[15];
      end else if (op == OP_MANTISSA_ALIGN_OP) begin
         fill = lower_half(cmd.mode) ? 1'b0 : ss_q;
      end else begin
         fill = 1'b0;
      end
      if (lower_half(cmd.mode)) begin
         placed = {{16{fill & (op == OP_ARITH_SHIFT_OP)}}, operand};   // RULE_15
      end else begin
         placed = {operand, 16'h0000};                         // RULE_15
      end
      wide = {{32{fill}}, placed};
      if (amt[7]) begin
         shifted = 32'(wide >> mag);
      end else begin
         shifted = placed << mag;
      end
   end

   // Status word as software sees it.
   always_comb begin
      arith_status_reg_word               = 32'h0000_0000;
      arith_status_reg_word[ARITH_STATUS_REG_SS_BIT] = ss_q;
      arith_status_reg_word[ARITH_STATUS_REG_AV_BIT] = alu_overflow_i;
   end

   // Read data for the addressed register; unmapped words read as zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(wb_adr_i, OFF_CMD)) begin
         rd_mux = cmd_q;
      end else if (hit(wb_adr_i, OFF_SI)) begin
         rd_mux = {16'h0000, si_q};
      end else if (hit(wb_adr_i, OFF_SE)) begin
         rd_mux = {24'h000000, se_q};
      end else if (hit(wb_adr_i, OFF_SB)) begin
         rd_mux = {24'h000000, sb_q};
      end else if (hit(wb_adr_i, OFF_SR)) begin
         rd_mux = sr_q;
      end else if (hit(wb_adr_i, OFF_ARITH_STATUS_REG)) begin
         rd_mux = arith_status_reg_word;
      end
   end

   // Bus slave answer: a one-cycle acknowledge with read data beside it. Data is
   // zero outside the acknowledge, so a stale word never looks valid.
   always_comb begin
      ack_d = req;
      dat_d = (req & ~wb_we_i) ? rd_mux : 32'h0000_0000;
   end

   // Registers of the bus slave.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   // Command, operand and result. A command write never targets the operand or
   // result words, so its result and a plain register write cannot collide.
   always_comb begin
      cmd_d = cmd_q;
      si_d  = si_q;
      sr_d  = sr_q;
      if (wr_si) begin
         si_d = 16'(lane_merge({16'h0000, si_q}, wb_dat_i, wb_sel_i));
      end
      if (wr_sr) begin
         sr_d = lane_merge(sr_q, wb_dat_i, wb_sel_i);
      end
      if (cmd_go) begin
         cmd_d = cmd;
         // Only the three shift operations move data into the result.
         if (moves_data(op)) begin                             // RULE_12
            if (cmd.or_into) begin
               sr_d = sr_q | shifted;                          // RULE_13
            end else begin
               sr_d = shifted;                                 // RULE_14
            end
         end
      end
   end

   // Registers of the command, operand and result.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_q <= CMD_RESET;
         si_q  <= SI_RESET;
         sr_q  <= SR_RESET;
      end else begin
         cmd_q <= cmd_d;
         si_q  <= si_d;
         sr_q  <= sr_d;
      end
   end

   // Exponent state: shift exponent, block exponent and the stored sign flag.
   always_comb begin
      se_d = se_q;
      sb_d = sb_q;
      ss_d = ss_q;
      if (wr_se) begin
         se_d = 8'(lane_merge({24'h000000, se_q}, wb_dat_i, wb_sel_i));
      end
      if (wr_sb) begin
         sb_d = 8'(lane_merge({24'h000000, sb_q}, wb_dat_i, wb_sel_i));
      end
      if (wr_ss) begin
         ss_d = wb_dat_i[ARITH_STATUS_REG_SS_BIT];
      end
      if (cmd_go) begin
         unique case (op)                                       // RULE_11
            OP_EXP: begin
               if (lower_half(cmd.mode)) begin
                  // Lower half only refines an upper half of all sign bits.
                  if (se_q == EXP_HI_FLOOR) begin               // RULE_07 RULE_09
                     se_d = det_exp;                            // RULE_17
                  end
               end else begin
                  se_d = det_exp;                               // RULE_17
                  ss_d = det_sign;                              // RULE_03
               end
            end
            OP_BLOCK_SCALE_ADJUST_OP: begin
               // Signed compare; data registers are left alone.
               if ($signed(det_exp) > $signed(sb_q)) begin     // RULE_10 RULE_19
                  sb_d = det_exp;
               end
            end
            default: begin
               // Shifts, immediate or not, and unused codes keep the exponents.
            end
         endcase
      end
   end

   // Registers of the exponent state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         se_q <= SE_RESET;
         sb_q <= SB_RESET;
         ss_q <= 1'b0;
      end else begin
         se_q <= se_d;
         sb_q <= sb_d;
         ss_q <= ss_d;
      end
   end

   // Outputs all come straight from flip-flops.
   assign wb_ack_o         = ack_q;
   assign wb_dat_o         = dat_q;
   assign shift_result_o   = sr_q;
   assign shift_exponent_o = se_q;
   assign block_exponent_o = sb_q;
   assign shifter_sign_o   = ss_q;

endmodule

// ===== tb/bse_props.sv
// Purpose: Port-level assertions for the barrel shifter exponent unit.
// Assumes: Commands are written with all four byte lanes enabled.
// Notes:   Bound into every bse_top instance below the module.

`timescale 1ns/1ps

module bse_props
   import bse_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [15:0] alu_result_i,
   input wire logic        alu_overflow_i,
   input wire logic [31:0] shift_result_o,
   input wire logic [7:0]  shift_exponent_o,
   input wire logic [7:0]  block_exponent_o,
   input wire logic        shifter_sign_o
);
   bse_cmd_t c;
   logic     tk;
   logic     cw;

   // Decode a command write at the edge that takes it; partial lane writes are not judged.
   assign c  = wb_dat_i;
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign cw = tk && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i == 4'hf;

   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_ack;
      tk |=> s_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a one-cycle pulse");
   property p_ack_src;
      wb_ack_o |-> $past(tk);
   endproperty
   a_ack_src: assert property (p_ack_src) else $error("ack without a request");
   property p_ovf;
      cw && c.op == OP_EXP && c.mode == MODE_HIX && alu_overflow_i && c.src == SRC_ALU
      |=> shift_exponent_o == EXP_OVF && shifter_sign_o != $past(alu_result_i[15]);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow exponent wrong");
   property p_sign;
      cw && c.op == OP_EXP && c.mode != MODE_LO && c.src == SRC_ALU
      && !(c.mode == MODE_HIX && alu_overflow_i) |=> shifter_sign_o == $past(alu_result_i[15]);
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag wrong");
   property p_hi_range;
      cw && c.op == OP_EXP && c.mode == MODE_HI
      |=> $signed(shift_exponent_o) <= 0 && $signed(shift_exponent_o) >= -15;
   endproperty
   a_hi_range: assert property (p_hi_range) else $error("upper exponent range");
   property p_lo_hold;
      cw && c.op == OP_EXP && c.mode == MODE_LO && shift_exponent_o != 8'hf1
      |=> $stable(shift_exponent_o);
   endproperty
   a_lo_hold: assert property (p_lo_hold) else $error("lower mode overwrote exponent");
   property p_lo_range;
      cw && c.op == OP_EXP && c.mode == MODE_LO && shift_exponent_o == 8'hf1
      |=> $signed(shift_exponent_o) <= -15 && $signed(shift_exponent_o) >= -31;
   endproperty
   a_lo_range: assert property (p_lo_range) else $error("lower exponent range");
   property p_blk;
      cw && c.op == OP_BLOCK_SCALE_ADJUST_OP |=> $signed(block_exponent_o) >= $signed($past(block_exponent_o));
   endproperty
   a_blk: assert property (p_blk) else $error("block exponent decreased");
   property p_adj;
      cw && c.op == OP_BLOCK_SCALE_ADJUST_OP |=> $stable(shift_result_o) && $stable(shift_exponent_o);
   endproperty
   a_adj: assert property (p_adj) else $error("block adjust changed data");
   property p_imm;
      cw && c.use_imm && c.op inside {OP_ARITH_SHIFT_OP, OP_LOGICAL_SHIFT_OP} |=> $stable(shift_exponent_o);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate shift touched exponent");
   property p_or;
      cw && c.or_into && c.op inside {OP_ARITH_SHIFT_OP, OP_LOGICAL_SHIFT_OP, OP_MANTISSA_ALIGN_OP}
      |=> (shift_result_o & $past(shift_result_o)) == $past(shift_result_o);
   endproperty
   a_or: assert property (p_or) else $error("merge lost result bits");
endmodule

bind bse_top bse_props bse_props_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alu_result_i(alu_result_i),
   .alu_overflow_i(alu_overflow_i), .shift_result_o(shift_result_o),
   .shift_exponent_o(shift_exponent_o), .block_exponent_o(block_exponent_o),
   .shifter_sign_o(shifter_sign_o)
);

// ===== tb/bse_alu_model.sv
// Purpose: Behavioural ALU result and overflow source feeding the shifter.
// Assumes: Loaded by the bench on a clock edge.
// Notes:   Holds its last result, as a result register does.

`timescale 1ns/1ps

module bse_alu_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ld_i,
   input  wire logic [15:0] val_i,
   input  wire logic        ovf_i,
   output logic      [15:0] alu_result_o,
   output logic             alu_overflow_o
);
   logic [15:0] res_q;
   logic [15:0] res_d;
   logic        ovf_q;
   logic        ovf_d;

   // A load replaces both result and flag together, so they never disagree.
   always_comb begin
      res_d = ld_i ? val_i : res_q;
      ovf_d = ld_i ? ovf_i : ovf_q;
   end

   // Register the result and flag.
   always_ff @(posedge clk_i) begin
      res_q <= rst_i ? 16'h0000 : res_d;
      ovf_q <= rst_i ? 1'b0 : ovf_d;
   end

   assign alu_result_o   = res_q;
   assign alu_overflow_o = ovf_q;
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for the barrel shifter exponent unit.
// Assumes: Registers are reached by classic Wishbone single cycles.
// Notes:   Reads note their expected data in a queue checked at ack.

`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb
   import bse_pkg::*;
();
   logic        clk_i, rst_i, cyc, stb, we, ack, ss, ld, lo, aovf;
   logic [7:0]  adr, se, sb;
   logic [3:0]  sel;
   logic [31:0] dat, rdat, sr, rs;
   logic [15:0] lv, ares, v;
   logic [31:0] expq[$];
   logic [31:0] exp_v;
   int          num_errors, check_count;

   bse_top bse_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .alu_result_i(ares), .alu_overflow_i(aovf), .shift_result_o(sr),
      .shift_exponent_o(se), .block_exponent_o(sb), .shifter_sign_o(ss));
   bse_alu_model bse_alu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .ld_i(ld), .val_i(lv),
      .ovf_i(lo), .alu_result_o(ares), .alu_overflow_o(aovf));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   function automatic logic [31:0] cmd(input logic [2:0] op, input logic [1:0] md,
      input logic orr, input logic imm, input logic [1:0] src, input logic [7:0] amt);
      return {8'h00, amt, 6'h00, src, 1'b0, imm, orr, md, op};
   endfunction

   task automatic results();
      if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One bus cycle; the wait is bounded so a silent slave ends the run.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      cyc <= 1'b0; stb <= 1'b0;
      if (n >= 50) begin
         num_errors++;
         results();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic ex(input logic [31:0] c);
      wb(1'b1, OFF_CMD, c);
   endtask
   task automatic alu(input logic [15:0] x, input logic o);
      @(posedge clk_i);
      ld <= 1'b1; lv <= x; lo <= o;
      @(posedge clk_i);
      ld <= 1'b0;
   endtask

   // Read data is judged against the oldest note when its ack arrives; the note
   // is taken off once, before the compare, so a report cannot pop a second one.
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (expq.size() == 0) begin
            `CHK("queue", 1'b1, 1'b0)
         end else begin
            exp_v = expq.pop_front();
            `CHK("rdata", exp_v, rdat)
         end
      end
   end

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   initial begin
      rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; sel = 0;
      ld = 0; lv = 0; lo = 0; rs = 32'h073f;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFF_SB, {24'h0, SB_RESET});
      rd(8'h18, 32'h0);
      // Every count of redundant sign bits, with random polarity.
      for (int k = 0; k < 16; k++) begin
         rs = xs(rs);
         v = rs[0] ? ~(16'h7fff >> k) : (16'h7fff >> k);
         wr(OFF_SI, {16'h0, v});
         ex(cmd(OP_EXP, MODE_HI, 0, 0, SRC_SI, 0));
         rd(OFF_SE, {24'h0, 8'(-k)});
         rd(OFF_ARITH_STATUS_REG, {31'h0, rs[0]});
      end
      for (int o = 0; o < 2; o++) begin
         alu({5'h01, rs[10:0]}, o[0]);
         ex(cmd(OP_EXP, MODE_HIX, 0, 0, SRC_ALU, 0));
         rd(OFF_SE, o ? 32'h01 : 32'hfd);
         rd(OFF_ARITH_STATUS_REG, o ? 32'h3 : 32'h0);
      end
      // Lower half uses the stored sign, not the operand's top bit.
      wr(OFF_ARITH_STATUS_REG, 32'h1); wr(OFF_SE, 32'hf1); wr(OFF_SI, 32'h0fff);
      ex(cmd(OP_EXP, MODE_LO, 0, 0, SRC_SI, 0));
      rd(OFF_SE, 32'hf1);
      wr(OFF_SI, 32'h0); ex(cmd(OP_EXP, MODE_HI, 0, 0, SRC_SI, 0));
      wr(OFF_SI, 32'h0fff); ex(cmd(OP_EXP, MODE_LO, 0, 0, SRC_SI, 0));
      rd(OFF_SE, 32'hed);
      wr(OFF_SI, 32'h0); ex(cmd(OP_EXP, MODE_LO, 0, 0, SRC_SI, 0));
      rd(OFF_SE, 32'hed);
      wr(OFF_SE, 32'hf1); ex(cmd(OP_EXP, MODE_LO, 0, 0, SRC_SI, 0));
      rd(OFF_SE, 32'he1);
      // Block exponent climbs only on a larger exponent.
      wr(OFF_SB, 32'hf0); wr(OFF_SI, 32'hf5b1); ex(cmd(OP_BLOCK_SCALE_ADJUST_OP, MODE_HI, 0, 0, SRC_SI, 0));
      rd(OFF_SB, 32'hfd);
      wr(OFF_SI, 32'h0176); ex(cmd(OP_BLOCK_SCALE_ADJUST_OP, MODE_HI, 0, 0, SRC_SI, 0));
      rd(OFF_SB, 32'hfd);
      rd(OFF_SR, 32'h0);
      rd(OFF_SE, 32'he1);
      // Immediate shifts in both directions and halves.
      wr(OFF_SI, 32'hb6a3);
      ex(cmd(OP_LOGICAL_SHIFT_OP, MODE_HI, 0, 1, SRC_SI, 8'hfb)); rd(OFF_SR, 32'h05b51800);
      ex(cmd(OP_ARITH_SHIFT_OP, MODE_HI, 0, 1, SRC_SI, 8'hfb)); rd(OFF_SR, 32'hfdb51800);
      ex(cmd(OP_LOGICAL_SHIFT_OP, MODE_LO, 0, 1, SRC_SI, 8'h05)); rd(OFF_SR, 32'h0016d460);
      rd(OFF_SE, 32'he1);
      ex(cmd(OP_LOGICAL_SHIFT_OP, MODE_HI, 0, 1, SRC_SR_LO, 0)); rd(OFF_SR, 32'hd4600000);
      // Double-precision denormalize, second half merged in.
      wr(OFF_SE, 32'hfd); ex(cmd(OP_ARITH_SHIFT_OP, MODE_HI, 0, 0, SRC_SI, 0));
      wr(OFF_SI, 32'h765d); ex(cmd(OP_LOGICAL_SHIFT_OP, MODE_LO, 1, 0, SRC_SI, 0));
      rd(OFF_SR, 32'hf6d46ecb);
      wr(OFF_SI, 32'hf6d0); ex(cmd(OP_MANTISSA_ALIGN_OP, MODE_HI, 0, 0, SRC_SI, 0));
      rd(OFF_SR, 32'hb6800000);
      rs = xs(rs);
      alu(rs[15:0], 1'b0);
      ex(cmd(OP_LOGICAL_SHIFT_OP, MODE_HI, 0, 1, SRC_ALU, 0)); rd(OFF_SR, {rs[15:0], 16'h0});
      // Upper result half fed back into the lower half, sign-extended into the upper half.
      ex(cmd(OP_ARITH_SHIFT_OP, MODE_LO, 0, 1, SRC_SR_HI, 0));
      rd(OFF_SR, {{16{rs[15]}}, rs[15:0]});
      repeat (3) @(posedge clk_i);
      // The register outputs must show what the bus reads back.
      `CHK("sr_port", {{16{rs[15]}}, rs[15:0]}, sr)
      `CHK("se_port", 8'hfd, se)
      `CHK("sb_port", 8'hfd, sb)
      `CHK("ss_port", 1'b0, ss)
      results();
   end
endmodule
